// ### logic/alarm_consts.svh
// Register indices, field positions and reset values of the alarm slice.
`ifndef ALARM_CONSTS_SVH
`define ALARM_CONSTS_SVH

// ------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------------
`define IDX_SENSOR_CTRL   8'h17
`define IDX_VOLT1_LIMITS  8'h1a
`define IDX_TEMP_LIMITS   8'h1b
`define IDX_CAM_ALARM_EN  8'h1c
`define IDX_SENS_ALARM_EN 8'h1d
`define IDX_BC_ALARM_EN   8'h1e
`define IDX_LANE_POL      8'h20
`define IDX_LP_POL        8'h21
`define IDX_HS_DEBUG      8'h22
`define IDX_LP_DEBUG      8'h23
`define IDX_TERM_DEBUG    8'h24
`define IDX_STATUS        8'h40
`define IDX_MASK          8'h41
`define IDX_VOLT1_MAX     8'h42
`define IDX_VOLT1_MIN     8'h43
`define IDX_RAW_FLAGS     8'h44

// ------------------------------------------------------------------
// Field positions and writable masks
// ------------------------------------------------------------------
`define LIMIT_HI_MSB      6
`define LIMIT_HI_LSB      4
`define LIMIT_LO_MSB      2
`define LIMIT_LO_LSB      0
`define LIMITS_MASK       8'h77
`define CAM_EN_MASK       8'h3f
`define SENS_EN_MASK      8'h3f
`define BC_EN_MASK        8'h03
`define LANE_POL_MASK     8'h1f
`define LP_POL_MASK       8'h1f
`define DEBUG_RX_MASK     8'h7f
`define TERM_MASK         8'h0f
`define SCTRL_MASK        8'h0f
`define SENS_ON_CODE      2'b11
`define SEL_GPIO0_BIT     0
`define SEL_GPIO1_BIT     1

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define RST_LIMITS        8'h62
`define RST_CAM_EN        8'h3f
`define RST_SENS_EN       8'h00
`define RST_BC_EN         8'h00
`define RST_ZERO8         8'h00
`define RST_SCTRL         8'h0c
`define RST_STATUS        14'h0000

`endif

// ### logic/alarm_pkg.sv
// Types shared by the alarm and lane configuration slice.
package alarm_pkg;

    typedef struct packed {
        logic [5:0] cam;     // Missing frame, sync, ctrl, ecc, chksum, len.
        logic [5:0] sens;    // T hi, T lo, V1 hi, V1 lo, V0 hi, V0 lo.
        logic [1:0] bc;      // Crc error, link detect.
    } alarm_vec_t;

    typedef struct packed {
        logic [4:0] lane_swap;
        logic       lp_clock_invert;
        logic [3:0] lp_data_invert;
        logic [6:0] hs_rx_debug;
        logic [6:0] lp_rx_debug;
        logic [3:0] termination_en;
    } lane_cfg_t;

    typedef struct packed {
        logic        pend;
        logic        wr;
        logic        hit;
        logic [7:0]  idx;
        logic [31:0] rdata;
        logic [7:0]  volt1_limits;
        logic [7:0]  temp_limits;
        logic [7:0]  cam_en;
        logic [7:0]  sens_en;
        logic [7:0]  bc_en;
        logic [7:0]  lane_pol;
        logic [7:0]  lp_pol;
        logic [7:0]  hs_dbg;
        logic [7:0]  lp_dbg;
        logic [7:0]  term;
        logic [7:0]  sctrl;
        logic [2:0]  vmax;
        logic [2:0]  vmin;
        logic [5:0]  raw;
        logic [13:0] status;
        logic [13:0] mask;
    } state_t;

endpackage : alarm_pkg

// ### logic/sensor_alarm_csi_lane_config.sv
// Alarm qualification, sensor limits and lane configuration registers.
//
// The AHB-Lite slave port answers with zero wait states and never signals an error.
`timescale 1ns/1ps
`include "alarm_consts.svh"

module sensor_alarm_csi_lane_config #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [ADDR_W-1:0]     haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    // Sensor measurements
    input  wire logic                  volt1_valid,
    input  wire logic [2:0]            volt1_level,
    input  wire logic                  temp_valid,
    input  wire logic [2:0]            temp_level,
    input  wire logic                  volt0_high,
    input  wire logic                  volt0_low,
    // Receive and back-channel events
    input  wire logic [5:0]            cam_err,
    input  wire logic [1:0]            bc_evt,
    // Alarms and configuration
    output alarm_pkg::alarm_vec_t      alarm_active,
    output alarm_pkg::lane_cfg_t       lane_cfg,
    output logic                       irq
);

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    alarm_pkg::state_t s_q;
    alarm_pkg::state_t s_d;

    logic              take;
    logic              sens_on;
    logic              v1_sel;
    logic              v0_sel;
    logic [13:0]       cond;
    logic [13:0]       qual;
    logic [13:0]       clr;
    logic [7:0]        wb;
    logic [5:0]        sens_evt;

    // Index decode; addresses outside the map give a miss.
    function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
        idx_of = a[9:2];
    endfunction : idx_of

    function automatic logic mapped(input logic [7:0] i);
        mapped = (i == `IDX_SENSOR_CTRL) || (i == `IDX_VOLT1_LIMITS) ||
                 (i == `IDX_TEMP_LIMITS) || (i == `IDX_CAM_ALARM_EN) ||
                 (i == `IDX_SENS_ALARM_EN) || (i == `IDX_BC_ALARM_EN) ||
                 (i == `IDX_LANE_POL) || (i == `IDX_LP_POL) ||
                 (i == `IDX_HS_DEBUG) || (i == `IDX_LP_DEBUG) ||
                 (i == `IDX_TERM_DEBUG) || (i == `IDX_STATUS) ||
                 (i == `IDX_MASK) || (i == `IDX_VOLT1_MAX) ||
                 (i == `IDX_VOLT1_MIN) || (i == `IDX_RAW_FLAGS);
    endfunction : mapped

    function automatic logic [31:0] read_reg(input logic [7:0] i,
                                             input alarm_pkg::state_t s);
        read_reg = 32'h0000_0000;
        if (i == `IDX_SENSOR_CTRL) begin
            read_reg[7:0] = s.sctrl;
        end else if (i == `IDX_VOLT1_LIMITS) begin
            read_reg[7:0] = s.volt1_limits;
        end else if (i == `IDX_TEMP_LIMITS) begin
            read_reg[7:0] = s.temp_limits;
        end else if (i == `IDX_CAM_ALARM_EN) begin
            read_reg[7:0] = s.cam_en;
        end else if (i == `IDX_SENS_ALARM_EN) begin
            read_reg[7:0] = s.sens_en;
        end else if (i == `IDX_BC_ALARM_EN) begin
            read_reg[7:0] = s.bc_en;
        end else if (i == `IDX_LANE_POL) begin
            read_reg[7:0] = s.lane_pol;
        end else if (i == `IDX_LP_POL) begin
            read_reg[7:0] = s.lp_pol;
        end else if (i == `IDX_HS_DEBUG) begin
            read_reg[7:0] = s.hs_dbg;
        end else if (i == `IDX_LP_DEBUG) begin
            read_reg[7:0] = s.lp_dbg;
        end else if (i == `IDX_TERM_DEBUG) begin
            read_reg[7:0] = s.term;
        end else if (i == `IDX_STATUS) begin
            read_reg[13:0] = s.status;
        end else if (i == `IDX_MASK) begin
            read_reg[13:0] = s.mask;
        end else if (i == `IDX_VOLT1_MAX) begin
            read_reg[2:0] = s.vmax;
        end else if (i == `IDX_VOLT1_MIN) begin
            read_reg[2:0] = s.vmin;
        end else if (i == `IDX_RAW_FLAGS) begin
            read_reg[5:0] = s.raw;
        end
    endfunction : read_reg

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        s_d     = s_q;
        take    = hsel && hready && htrans[1];
        wb      = hwdata[7:0];
        sens_on = (s_q.sctrl[3:2] == `SENS_ON_CODE);
        // A cleared sensor enable field silences the voltage inputs too.
        v1_sel  = s_q.sctrl[`SEL_GPIO1_BIT] && sens_on;
        v0_sel  = s_q.sctrl[`SEL_GPIO0_BIT] && sens_on;
        clr     = 14'h0000;
        sens_evt = 6'h00;

        // Limit comparisons run regardless of the alarm enables.
        if (volt1_valid && v1_sel) begin
            s_d.raw[3] = volt1_level >
                s_q.volt1_limits[`LIMIT_HI_MSB:`LIMIT_HI_LSB];
            s_d.raw[2] = volt1_level <
                s_q.volt1_limits[`LIMIT_LO_MSB:`LIMIT_LO_LSB];
            sens_evt[3:2] = s_d.raw[3:2];
            if (volt1_level > s_q.vmax) begin
                s_d.vmax = volt1_level;
            end
            if (volt1_level < s_q.vmin) begin
                s_d.vmin = volt1_level;
            end
        end
        if (temp_valid && sens_on) begin
            s_d.raw[5] = temp_level >
                s_q.temp_limits[`LIMIT_HI_MSB:`LIMIT_HI_LSB];
            s_d.raw[4] = temp_level <
                s_q.temp_limits[`LIMIT_LO_MSB:`LIMIT_LO_LSB];
            sens_evt[5:4] = s_d.raw[5:4];
        end
        s_d.raw[1] = volt0_high && v0_sel;
        s_d.raw[0] = volt0_low && v0_sel;
        sens_evt[1:0] = s_d.raw[1:0];

        // Sensor alarms latch from the sample itself, not from the held raw
        // flags, so that a one written to status really clears a stale bit.
        cond = {cam_err, sens_evt, bc_evt};
        qual = cond & {s_q.cam_en[5:0], s_q.sens_en[5:0],
                       s_q.bc_en[1:0]};

        // Bus data phase: writes land here, reads were fetched earlier.
        if (s_q.pend && s_q.wr && s_q.hit) begin
            if (s_q.idx == `IDX_SENSOR_CTRL) begin
                s_d.sctrl = wb & `SCTRL_MASK;
            end else if (s_q.idx == `IDX_VOLT1_LIMITS) begin
                s_d.volt1_limits = wb & `LIMITS_MASK;
            end else if (s_q.idx == `IDX_TEMP_LIMITS) begin
                s_d.temp_limits = wb & `LIMITS_MASK;
            end else if (s_q.idx == `IDX_CAM_ALARM_EN) begin
                s_d.cam_en = wb & `CAM_EN_MASK;
            end else if (s_q.idx == `IDX_SENS_ALARM_EN) begin
                s_d.sens_en = wb & `SENS_EN_MASK;
            end else if (s_q.idx == `IDX_BC_ALARM_EN) begin
                s_d.bc_en = wb & `BC_EN_MASK;
            end else if (s_q.idx == `IDX_LANE_POL) begin
                s_d.lane_pol = wb & `LANE_POL_MASK;
            end else if (s_q.idx == `IDX_LP_POL) begin
                s_d.lp_pol = wb & `LP_POL_MASK;
            end else if (s_q.idx == `IDX_HS_DEBUG) begin
                s_d.hs_dbg = wb & `DEBUG_RX_MASK;
            end else if (s_q.idx == `IDX_LP_DEBUG) begin
                s_d.lp_dbg = wb & `DEBUG_RX_MASK;
            end else if (s_q.idx == `IDX_TERM_DEBUG) begin
                s_d.term = wb & `TERM_MASK;
            end else if (s_q.idx == `IDX_STATUS) begin
                clr = hwdata[13:0];
            end else if (s_q.idx == `IDX_MASK) begin
                s_d.mask = hwdata[13:0];
            end
        end

        // A new alarm in the clearing cycle stays set.
        s_d.status = (s_q.status & ~clr) | qual;

        s_d.pend = take;
        if (take) begin
            s_d.wr    = hwrite;
            s_d.idx   = idx_of(haddr);
            s_d.hit   = mapped(idx_of(haddr)) &&
                        (haddr[ADDR_W-1:10] == '0);
            s_d.rdata = hwrite ? 32'h0000_0000 :
                        (s_d.hit ? read_reg(idx_of(haddr), s_q)
                                 : 32'h0000_0000);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            s_q              <= '0;
            s_q.volt1_limits <= `RST_LIMITS;
            s_q.temp_limits  <= `RST_LIMITS;
            s_q.cam_en       <= `RST_CAM_EN;
            s_q.sens_en      <= `RST_SENS_EN;
            s_q.bc_en        <= `RST_BC_EN;
            s_q.lane_pol     <= `RST_ZERO8;
            s_q.lp_pol       <= `RST_ZERO8;
            s_q.hs_dbg       <= `RST_ZERO8;
            s_q.lp_dbg       <= `RST_ZERO8;
            s_q.term         <= `RST_ZERO8;
            s_q.sctrl        <= `RST_SCTRL;
            s_q.vmin         <= 3'h7;
            s_q.status       <= `RST_STATUS;
        end else begin
            s_q <= s_d;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = s_q.rdata;
    assign irq       = |(s_q.status & s_q.mask);

    assign alarm_active = {s_q.status[13:8] & s_q.cam_en[5:0],
                           s_q.status[7:2] & s_q.sens_en[5:0],
                           s_q.status[1:0] & s_q.bc_en[1:0]};

    assign lane_cfg.lane_swap       = s_q.lane_pol[4:0];
    assign lane_cfg.lp_clock_invert = s_q.lp_pol[4];
    assign lane_cfg.lp_data_invert  = s_q.lp_pol[3:0];
    assign lane_cfg.hs_rx_debug     = s_q.hs_dbg[6:0];
    assign lane_cfg.lp_rx_debug     = s_q.lp_dbg[6:0];
    assign lane_cfg.termination_en  = s_q.term[3:0];

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    chk_volt1_high_flag: assert property (
        volt1_valid && v1_sel &&
        (volt1_level > s_q.volt1_limits[6:4])
        |=> s_q.raw[3])
        else $error("volt1 high flag not set");

    chk_volt1_low_flag: assert property (
        volt1_valid && v1_sel &&
        !(volt1_level < s_q.volt1_limits[2:0])
        |=> !s_q.raw[2])
        else $error("volt1 low flag set without cause");

    chk_volt1_max_track: assert property (
        volt1_valid && v1_sel
        |=> s_q.vmax >= $past(volt1_level))
        else $error("volt1 maximum below a seen reading");

    chk_volt1_min_track: assert property (
        volt1_valid && v1_sel
        |=> s_q.vmin <= $past(volt1_level))
        else $error("volt1 minimum above a seen reading");

    chk_temp_high_flag: assert property (
        temp_valid && sens_on && (temp_level > s_q.temp_limits[6:4])
        |=> s_q.raw[5])
        else $error("temperature high flag not set");

    chk_temp_off_hold: assert property (
        !sens_on && !(s_q.pend && s_q.wr)
        |=> $stable(s_q.raw[5:4]))
        else $error("temperature flags moved while disabled");

    chk_cam_alarm_set: assert property (
        |(cam_err & s_q.cam_en[5:0])
        |=> (s_q.status[13:8] & $past(cam_err & s_q.cam_en[5:0]))
            == $past(cam_err & s_q.cam_en[5:0]))
        else $error("enabled camera alarm not latched");

    chk_sens_alarm_mask: assert property (
        s_q.sens_en[5:0] == 6'h00 |-> alarm_active.sens == 6'h00)
        else $error("sensor alarm reported while disabled");

    chk_bc_alarm_gate: assert property (
        bc_evt[0] && !s_q.bc_en[0] && !s_q.status[0]
        |=> !s_q.status[0])
        else $error("disabled link alarm latched");

    chk_lane_swap_write: assert property (
        s_q.pend && s_q.wr && s_q.hit && (s_q.idx == `IDX_LANE_POL)
        |=> lane_cfg.lane_swap == $past(hwdata[4:0]) &&
            s_q.lane_pol[7:5] == 3'h0)
        else $error("lane swap write not applied");

    chk_irq_from_status: assert property (
        (s_q.status == 14'h0000) && (cam_err == 6'h00) &&
        (bc_evt == 2'b00) && !volt1_valid && !temp_valid &&
        !volt0_high && !volt0_low
        |=> !irq)
        else $error("interrupt without unmasked status");

    chk_temp_low_flag: assert property (
        temp_valid && sens_on && (temp_level < s_q.temp_limits[2:0])
        |=> s_q.raw[4])
        else $error("temperature low flag not set");

    chk_sens_alarm_latch: assert property (
        volt1_valid && v1_sel && s_q.sens_en[3] &&
        (volt1_level > s_q.volt1_limits[6:4])
        |=> s_q.status[5])
        else $error("enabled volt1 high alarm not latched");

    chk_cam_alarm_gate: assert property (
        cam_err[1] && !s_q.cam_en[1] && !s_q.status[9]
        |=> !s_q.status[9])
        else $error("disabled camera alarm latched");

    chk_lp_invert_write: assert property (
        s_q.pend && s_q.wr && s_q.hit && (s_q.idx == `IDX_LP_POL)
        |=> lane_cfg.lp_clock_invert == $past(hwdata[4]) &&
            lane_cfg.lp_data_invert == $past(hwdata[3:0]))
        else $error("low-power inversion write not applied");

    chk_term_write: assert property (
        s_q.pend && s_q.wr && s_q.hit && (s_q.idx == `IDX_TERM_DEBUG)
        |=> lane_cfg.termination_en == $past(hwdata[3:0]) &&
            s_q.term[7:4] == 4'h0)
        else $error("termination write not applied");

    chk_v1_select_gate: assert property (
        !v1_sel |=> $stable(s_q.raw[3:2]) && $stable(s_q.vmax) &&
            $stable(s_q.vmin))
        else $error("volt1 readings moved without selection");

    chk_volt0_off_gate: assert property (
        !sens_on |=> s_q.raw[1:0] == 2'b00)
        else $error("volt0 flags set while sensors disabled");

endmodule : sensor_alarm_csi_lane_config

// ### bench/test_sensor_alarm_csi_lane_config.sv
// Self-checking bench for the alarm and lane configuration slice.
`timescale 1ns/1ps
`include "alarm_consts.svh"

module test_sensor_alarm_csi_lane_config;
    logic                  mclk;
    logic                  rstn;
    logic                  hsel;
    logic [11:0]           haddr;
    logic [1:0]            htrans;
    logic                  hwrite;
    logic [31:0]           hwdata;
    logic [2:0]            hsize;
    logic                  hreadyout;
    logic                  hresp;
    logic [31:0]           hrdata;
    logic                  volt1_valid;
    logic [2:0]            volt1_level;
    logic                  temp_valid;
    logic [2:0]            temp_level;
    logic                  volt0_high;
    logic                  volt0_low;
    logic [5:0]            cam_err;
    logic [1:0]            bc_evt;
    alarm_pkg::alarm_vec_t alarm_active;
    alarm_pkg::lane_cfg_t  lane_cfg;
    logic                  irq;
    int                    miscompares;
    int                    comparisons;
    logic [7:0]            idx_tab [14] = '{8'h1a, 8'h1b, 8'h1c, 8'h1d,
        8'h1e, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h17, 8'h42, 8'h43, 8'h40};
    logic [31:0]           rst_tab [14] = '{32'h62, 32'h62, 32'h3f, 32'h0,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0c, 32'h0, 32'h7, 32'h0};
    logic [31:0]           ones_tab [10] = '{32'h77, 32'h77, 32'h3f, 32'h3f,
        32'h03, 32'h1f, 32'h1f, 32'h7f, 32'h7f, 32'h0f};

    sensor_alarm_csi_lane_config #(.ADDR_W(12)) dut_u (
        .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .volt1_valid(volt1_valid),
        .volt1_level(volt1_level), .temp_valid(temp_valid),
        .temp_level(temp_level), .volt0_high(volt0_high),
        .volt0_low(volt0_low),
        .cam_err(cam_err), .bc_evt(bc_evt), .alarm_active(alarm_active),
        .lane_cfg(lane_cfg), .irq(irq));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic close_out;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val

    task automatic wait_ready;
        do begin
            @(posedge mclk);
        end while (hreadyout !== 1'b1);
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {2'b00, idx, 2'b00};
        hsize  <= 3'b010;
        wait_ready();
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, idx, d, r);
        // The write lands on the last bus edge; let it settle.
        @(posedge mclk);
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, idx, 32'h0, r);
        check_val(r, exp);
    endtask : rd_chk

    task automatic events(input logic [7:0] ev);
        {cam_err, bc_evt} <= ev;
        @(posedge mclk);
        {cam_err, bc_evt} <= 8'h00;
        repeat (3) @(posedge mclk);
    endtask : events

    task automatic sample(input logic t, input logic [2:0] lvl);
        volt1_valid <= !t;
        temp_valid  <= t;
        volt1_level <= lvl;
        temp_level  <= lvl;
        @(posedge mclk);
        volt1_valid <= 1'b0;
        temp_valid  <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : sample

    // ------------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    initial begin
        repeat (6000) @(posedge mclk);
        miscompares++;
        close_out();
    end

    initial begin
        logic [31:0] exp;
        {hsel, haddr, htrans, hwrite, hwdata, hsize} = '0;
        {volt1_valid, volt1_level, temp_valid, temp_level} = '0;
        {cam_err, bc_evt, volt0_high, volt0_low, rstn} = '0;
        miscompares = 0;
        comparisons = 0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        check_val({4'h0, lane_cfg}, 32'h0);
        check_val({17'h0, irq, alarm_active}, 32'h0);
        for (int i = 0; i < 14; i++) begin
            rd_chk(idx_tab[i], rst_tab[i]);
        end
        for (int i = 0; i < 10; i++) begin
            wr(idx_tab[i], 32'hffffffff);
            rd_chk(idx_tab[i], ones_tab[i]);
        end
        check_val({4'h0, lane_cfg}, 32'h0fffffff);
        for (int i = 0; i < 10; i++) begin
            wr(idx_tab[i], rst_tab[i]);
        end
        wr(8'h30, 32'hffffffff);
        rd_chk(8'h30, 32'h0);
        wr(8'h1e, 32'h3);
        for (int i = 0; i < 8; i++) begin
            events(8'h01 << i);
            exp = (i < 2) ? (32'h1 << i) : (32'h1 << (i + 6));
            rd_chk(8'h40, exp);
            check_val({18'h0, alarm_active}, exp);
            check_val({31'h0, irq}, 32'h0);
            wr(8'h40, exp);
            rd_chk(8'h40, 32'h0);
        end
        wr(8'h41, 32'h200);
        events(8'h08);
        check_val({31'h0, irq}, 32'h1);
        wr(8'h1c, 32'h0);
        check_val({18'h0, alarm_active}, 32'h0);
        wr(8'h40, 32'h200);
        check_val({31'h0, irq}, 32'h0);
        events(8'h08);
        rd_chk(8'h40, 32'h0);
        wr(8'h1c, 32'h3f);
        sample(1'b0, 3'h7);
        rd_chk(8'h44, 32'h0);
        rd_chk(8'h42, 32'h0);
        wr(8'h17, 32'h0e);
        wr(8'h1d, 32'h3c);
        sample(1'b0, 3'h6);
        rd_chk(8'h40, 32'h0);
        sample(1'b0, 3'h7);
        rd_chk(8'h40, 32'h20);
        rd_chk(8'h44, 32'h08);
        rd_chk(8'h42, 32'h7);
        sample(1'b0, 3'h1);
        rd_chk(8'h40, 32'h30);
        rd_chk(8'h43, 32'h1);
        wr(8'h40, 32'h30);
        sample(1'b1, 3'h7);
        rd_chk(8'h40, 32'h80);
        sample(1'b1, 3'h0);
        rd_chk(8'h40, 32'hc0);
        wr(8'h40, 32'hc0);
        wr(8'h1a, 32'h31);
        sample(1'b0, 3'h4);
        rd_chk(8'h40, 32'h20);
        wr(8'h40, 32'h20);
        wr(8'h1d, 32'h0);
        sample(1'b0, 3'h7);
        rd_chk(8'h40, 32'h0);
        rd_chk(8'h44, 32'h18);
        wr(8'h17, 32'h0d);
        wr(8'h1d, 32'h01);
        volt0_low <= 1'b1;
        @(posedge mclk);
        volt0_low <= 1'b0;
        rd_chk(8'h40, 32'h04);
        wr(8'h40, 32'h04);
        rd_chk(8'h40, 32'h0);
        wr(8'h17, 32'h02);
        wr(8'h1d, 32'h30);
        sample(1'b1, 3'h7);
        rd_chk(8'h40, 32'h0);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rd_chk(8'h42, 32'h0);
        rd_chk(8'h17, 32'h0c);
        check_val({31'h0, hresp}, 32'h0);
        close_out();
    end

endmodule : test_sensor_alarm_csi_lane_config
